// ===== common/mesim_consts.svh
// offsets, field positions, reset values and counts of the event block
`ifndef MESIM_CONSTS_SVH
`define MESIM_CONSTS_SVH

// register byte offsets
`define MESIM_OFS_TXQ_PTR   12'h01C
`define MESIM_OFS_RX_FLAGS  12'h020
`define MESIM_OFS_IRQ_FLAGS 12'h024
`define MESIM_OFS_UNMASK    12'h028
`define MESIM_OFS_MASK      12'h02C
`define MESIM_OFS_MASK_ST   12'h030

// receive flag bits
`define MESIM_RX_NOBUF    0
`define MESIM_RX_STORED   1
`define MESIM_RX_OVERRUN  2
`define MESIM_RX_W        3

// interrupt source bits
`define MESIM_IRQ_MGMT_DONE   0
`define MESIM_IRQ_RX_DONE     1
`define MESIM_IRQ_RX_USED     2
`define MESIM_IRQ_TX_USED     3
`define MESIM_IRQ_TX_UNDER    4
`define MESIM_IRQ_RETRY       5
`define MESIM_IRQ_TX_EXHAUST  6
`define MESIM_IRQ_TX_DONE     7
`define MESIM_IRQ_RX_OVERRUN  10
`define MESIM_IRQ_BUS_ERR     11
`define MESIM_IRQ_PAUSE_RX    12
`define MESIM_IRQ_PAUSE_ZERO  13
`define MESIM_IRQ_W      14
`define MESIM_IRQ_IMPL   14'h3CFF

// reset values
`define MESIM_RST_MASK   14'h3CFF
`define MESIM_RST_PTR    32'h0000_0000

`endif

// ===== common/mesim_pkg.sv
// types of the event status and interrupt mask block
`include "mesim_consts.svh"
package mesim_pkg;
  typedef logic [`MESIM_IRQ_W-1:0] mesim_irq_t;
  typedef logic [`MESIM_RX_W-1:0]  mesim_rx_t;
  typedef enum logic {MESIM_IDLE, MESIM_ACCESS} mesim_bus_t;
endpackage

// ===== hdl/mesim_top.sv
// event status, interrupt masking and queue pointer readback of a MAC
`timescale 1ns/1ps
`include "mesim_consts.svh"

module mesim_top #(
  parameter int PTR_W = 32
) (
  input  wire logic              sys_clk_i,
  input  wire logic              rst_i,
  input  wire logic              clk_en_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [11:0]       paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  input  wire logic              rx_fetch_owned_by_cpu_i,
  input  wire logic              rx_frame_stored_i,
  input  wire logic              rx_overrun_i,
  input  wire logic              mgmt_done_i,
  input  wire logic              rx_used_hit_i,
  input  wire logic              tx_used_hit_i,
  input  wire logic              tx_underrun_i,
  input  wire logic              tx_retry_limit_i,
  input  wire logic              tx_exhausted_i,
  input  wire logic              tx_complete_i,
  input  wire logic              bus_error_i,
  input  wire logic              pause_frame_i,
  input  wire logic              pause_zero_i,
  input  wire logic              tx_frame_start_i,
  input  wire logic [PTR_W-1:0]  tx_frame_first_buf_i,
  input  wire logic              tx_active_i,
  output logic [PTR_W-1:0]       txq_ptr_wr_o,
  output logic                   txq_ptr_load_o,
  output logic                   rx_refetch_o,
  output logic                   irq_o
);
  import mesim_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    mesim_bus_t       bus;
    logic [31:0]      rdata;
    logic             ready;
    logic             err;
    mesim_rx_t        rx;
    mesim_irq_t       isr;
    mesim_irq_t       mask;
    logic [PTR_W-1:0] ptr;
    logic [PTR_W-1:0] ptr_wr;
    logic             ptr_load;
    logic             refetch;
    logic             irq;
  } mesim_state_t;

  mesim_state_t st;
  mesim_state_t next_st;

  logic        acc;
  logic        wr_hit;
  logic        rd_hit;
  logic        bad_addr;
  mesim_irq_t  ev;
  mesim_irq_t  wmask;
  mesim_rx_t   rx_ev;
  logic [31:0] rd_mux;

  // ------------------------------------------------------------
  // event gathering
  // ------------------------------------------------------------
  // one access phase per transfer: answer comes out of a registered cycle
  assign acc    = psel_i & penable_i & (st.bus == MESIM_ACCESS);
  assign wr_hit = acc & pwrite_i;
  assign rd_hit = acc & ~pwrite_i;
  assign wmask  = pwdata_i[`MESIM_IRQ_W-1:0] & `MESIM_IRQ_IMPL;

  always_comb begin
    rx_ev = '0;
    rx_ev[`MESIM_RX_NOBUF]   = rx_fetch_owned_by_cpu_i;
    rx_ev[`MESIM_RX_STORED]  = rx_frame_stored_i;
    rx_ev[`MESIM_RX_OVERRUN] = rx_overrun_i;
    ev = '0;
    ev[`MESIM_IRQ_MGMT_DONE]  = mgmt_done_i;
    ev[`MESIM_IRQ_RX_DONE]    = rx_frame_stored_i;
    ev[`MESIM_IRQ_RX_USED]    = rx_used_hit_i;
    ev[`MESIM_IRQ_TX_USED]    = tx_used_hit_i;
    ev[`MESIM_IRQ_TX_UNDER]   = tx_underrun_i | (wr_hit & ~tx_active_i &
                                (paddr_i == `MESIM_OFS_TXQ_PTR));
    ev[`MESIM_IRQ_RETRY]      = tx_retry_limit_i;
    ev[`MESIM_IRQ_TX_DONE]    = tx_complete_i;
    ev[`MESIM_IRQ_TX_EXHAUST] = tx_exhausted_i;
    ev[`MESIM_IRQ_RX_OVERRUN] = rx_overrun_i & ~st.rx[`MESIM_RX_OVERRUN];
    ev[`MESIM_IRQ_BUS_ERR]    = bus_error_i;
    ev[`MESIM_IRQ_PAUSE_RX]   = pause_frame_i;
    ev[`MESIM_IRQ_PAUSE_ZERO] = pause_zero_i;
  end

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  always_comb begin
    rd_mux   = '0;
    bad_addr = 1'b0;
    case (paddr_i)
      // frame start pointer, not descriptor pointer
      `MESIM_OFS_TXQ_PTR:   rd_mux = 32'(st.ptr);
      `MESIM_OFS_RX_FLAGS:  rd_mux = 32'(st.rx);
      `MESIM_OFS_IRQ_FLAGS: rd_mux = 32'(st.isr);
      `MESIM_OFS_UNMASK:    rd_mux = '0;
      `MESIM_OFS_MASK:      rd_mux = '0;
      `MESIM_OFS_MASK_ST:   rd_mux = 32'(st.mask);
      default:              bad_addr = 1'b1;
    endcase
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    next_st          = st;
    next_st.ready    = 1'b0;
    next_st.err      = 1'b0;
    next_st.ptr_load = 1'b0;
    next_st.refetch  = 1'b0;
    // bus phase tracker
    case (st.bus)
      MESIM_IDLE: begin
        if (psel_i && !penable_i) begin
          next_st.bus = MESIM_ACCESS;
        end
      end
      MESIM_ACCESS: begin
        if (acc) begin
          next_st.ready = 1'b1;
          next_st.err   = bad_addr;
          next_st.rdata = rd_mux;
          next_st.bus   = MESIM_IDLE;
        end
      end
      default: next_st.bus = MESIM_IDLE;
    endcase
    // write one clears; set wins over clear
    if (wr_hit && paddr_i == `MESIM_OFS_RX_FLAGS) begin
      next_st.rx = st.rx & ~pwdata_i[`MESIM_RX_W-1:0];
    end
    next_st.rx = next_st.rx | rx_ev;
    // ask the DMA to refetch at each stored frame while unavailable
    next_st.refetch = st.rx[`MESIM_RX_NOBUF] & rx_frame_stored_i;
    // clear on read, new events win over the read
    if (rd_hit && paddr_i == `MESIM_OFS_IRQ_FLAGS) begin
      next_st.isr = '0;
    end
    next_st.isr = (next_st.isr | ev) & `MESIM_IRQ_IMPL;
    if (wr_hit && paddr_i == `MESIM_OFS_UNMASK) begin
      next_st.mask = st.mask & ~wmask;
    end
    if (wr_hit && paddr_i == `MESIM_OFS_MASK) begin
      next_st.mask = st.mask | wmask;
    end
    next_st.mask = next_st.mask & `MESIM_IRQ_IMPL;
    // software pointer load only while transmit idle
    if (wr_hit && paddr_i == `MESIM_OFS_TXQ_PTR && !tx_active_i) begin
      next_st.ptr      = pwdata_i[PTR_W-1:0];
      next_st.ptr_wr   = pwdata_i[PTR_W-1:0];
      next_st.ptr_load = 1'b1;
    end else if (tx_frame_start_i) begin
      next_st.ptr = tx_frame_first_buf_i;
    end
    // any unmasked flag raises the output
    next_st.irq = |(next_st.isr & ~next_st.mask);
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st          <= '0;
      st.bus      <= MESIM_IDLE;
      st.mask     <= `MESIM_RST_MASK;
      st.ptr      <= PTR_W'(`MESIM_RST_PTR);
      st.ptr_wr   <= PTR_W'(`MESIM_RST_PTR);
    end else if (clk_en_i) begin
      st <= next_st;
    end
  end

  assign prdata_o       = st.rdata;
  assign pready_o       = st.ready;
  assign pslverr_o      = st.err;
  assign txq_ptr_wr_o   = st.ptr_wr;
  assign txq_ptr_load_o = st.ptr_load;
  assign rx_refetch_o   = st.refetch;
  assign irq_o          = st.irq;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_rx_clr;
    wr_hit && paddr_i == `MESIM_OFS_RX_FLAGS && pwdata_i[0] &&
    !rx_fetch_owned_by_cpu_i && clk_en_i;
  endsequence

  property p_rx_w1c;
    @(posedge sys_clk_i) disable iff (rst_i)
      s_rx_clr |=> !st.rx[`MESIM_RX_NOBUF];
  endproperty
  a_rx_w1c: assert property (p_rx_w1c)
    else $error("receive flag not cleared by write one");

  property p_bna_set;
    @(posedge sys_clk_i) disable iff (rst_i)
      rx_fetch_owned_by_cpu_i && clk_en_i |=> st.rx[`MESIM_RX_NOBUF];
  endproperty
  a_bna_set: assert property (p_bna_set)
    else $error("buffer unavailable flag missed a failed fetch");

  property p_rec_set;
    @(posedge sys_clk_i) disable iff (rst_i)
      rx_frame_stored_i && clk_en_i |=>
        st.rx[`MESIM_RX_STORED] && st.isr[`MESIM_IRQ_RX_DONE];
  endproperty
  a_rec_set: assert property (p_rec_set)
    else $error("frame received flags not set");

  property p_isr_rc;
    @(posedge sys_clk_i) disable iff (rst_i)
      rd_hit && paddr_i == `MESIM_OFS_IRQ_FLAGS && ev == '0 && clk_en_i
        |=> st.isr == '0;
  endproperty
  a_isr_rc: assert property (p_isr_rc)
    else $error("interrupt flags not cleared on read");

  property p_receive_overrun_event;
    @(posedge sys_clk_i) disable iff (rst_i)
      rx_overrun_i && !st.rx[`MESIM_RX_OVERRUN] && clk_en_i |=>
        st.isr[`MESIM_IRQ_RX_OVERRUN] && st.rx[`MESIM_RX_OVERRUN];
  endproperty
  a_receive_overrun_event: assert property (p_receive_overrun_event)
    else $error("overrun interrupt not raised with flag");

  property p_unmask;
    @(posedge sys_clk_i) disable iff (rst_i)
      wr_hit && paddr_i == `MESIM_OFS_UNMASK && pwdata_i[0] && clk_en_i
        |=> !st.mask[0];
  endproperty
  a_unmask: assert property (p_unmask)
    else $error("enable write did not unmask");

  property p_mask;
    @(posedge sys_clk_i) disable iff (rst_i)
      wr_hit && paddr_i == `MESIM_OFS_MASK && pwdata_i[0] && clk_en_i
        |=> st.mask[0];
  endproperty
  a_mask: assert property (p_mask)
    else $error("disable write did not mask");

  property p_resv;
    @(posedge sys_clk_i) disable iff (rst_i)
      (st.mask & ~`MESIM_IRQ_IMPL) == '0 &&
      (st.isr & ~`MESIM_IRQ_IMPL) == '0;
  endproperty
  a_resv: assert property (p_resv)
    else $error("reserved bit set");

  property p_irq;
    @(posedge sys_clk_i) disable iff (rst_i)
      st.irq == |(st.isr & ~st.mask);
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt output disagrees with flags and mask");

  property p_ptr;
    @(posedge sys_clk_i) disable iff (rst_i)
      tx_frame_start_i && !wr_hit && clk_en_i |=>
        st.ptr == $past(tx_frame_first_buf_i);
  endproperty
  a_ptr: assert property (p_ptr)
    else $error("queue pointer does not follow frame start");

  property p_rx_no_set;
    @(posedge sys_clk_i) disable iff (rst_i)
      wr_hit && paddr_i == `MESIM_OFS_RX_FLAGS && rx_ev == '0 && clk_en_i
        |=> (st.rx & ~$past(st.rx)) == '0;
  endproperty
  a_rx_no_set: assert property (p_rx_no_set)
    else $error("write set a receive flag");

  property p_ovr_set;
    @(posedge sys_clk_i) disable iff (rst_i)
      rx_overrun_i && clk_en_i |=> st.rx[`MESIM_RX_OVERRUN];
  endproperty
  a_ovr_set: assert property (p_ovr_set)
    else $error("overrun flag missed");

  property p_refetch;
    @(posedge sys_clk_i) disable iff (rst_i)
      st.rx[`MESIM_RX_NOBUF] && rx_frame_stored_i && clk_en_i
        |=> st.refetch;
  endproperty
  a_refetch: assert property (p_refetch)
    else $error("refetch request missing");

  property p_rx_used;
    @(posedge sys_clk_i) disable iff (rst_i)
      rx_used_hit_i && clk_en_i |=> st.isr[`MESIM_IRQ_RX_USED];
  endproperty
  a_rx_used: assert property (p_rx_used)
    else $error("used receive descriptor not flagged");

  property p_tx_used;
    @(posedge sys_clk_i) disable iff (rst_i)
      tx_used_hit_i && clk_en_i |=> st.isr[`MESIM_IRQ_TX_USED];
  endproperty
  a_tx_used: assert property (p_tx_used)
    else $error("used transmit descriptor not flagged");

  property p_ptr_ev;
    @(posedge sys_clk_i) disable iff (rst_i)
      wr_hit && paddr_i == `MESIM_OFS_TXQ_PTR && !tx_active_i && clk_en_i
        |=> st.isr[`MESIM_IRQ_TX_UNDER] && st.ptr_load;
  endproperty
  a_ptr_ev: assert property (p_ptr_ev)
    else $error("pointer write did not raise underrun flag");

  property p_mask_rd;
    @(posedge sys_clk_i) disable iff (rst_i)
      rd_hit && paddr_i == `MESIM_OFS_MASK_ST && clk_en_i
        |=> st.ready && st.rdata == 32'($past(st.mask));
  endproperty
  a_mask_rd: assert property (p_mask_rd)
    else $error("mask state read wrong");

  property p_pause;
    @(posedge sys_clk_i) disable iff (rst_i)
      pause_frame_i && clk_en_i |=> st.isr[`MESIM_IRQ_PAUSE_RX];
  endproperty
  a_pause: assert property (p_pause)
    else $error("pause frame not flagged");
endmodule

// ===== test/mac_event_status_and_irq_mask_test.sv
// self-checking bench of the event status and interrupt mask block
`timescale 1ns/1ps
`include "mesim_consts.svh"
module mac_event_status_and_irq_mask_test;
  // ------------------------------------------------------------
  // stimulus, observed outputs and model state
  // ------------------------------------------------------------
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  // expected flags per event, in the order of the ev bits below
  localparam logic [31:0] IRQ_TAB [0:12] = '{32'h0, 32'h2, 32'h400,
    32'h1, 32'h4, 32'h8, 32'h10, 32'h20, 32'h40, 32'h80, 32'h800,
    32'h1000, 32'h2000};
  localparam logic [31:0] RX_TAB [0:12] = '{0: 32'h1, 1: 32'h2,
    2: 32'h4, default: 32'h0};
  logic        sys_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [12:0] ev = 13'h0;
  logic        fstart = 1'b0;
  logic [31:0] fbuf = 32'h0;
  logic        tx_act = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] ptr_wr;
  logic        ptr_ld;
  logic        refetch;
  logic        irq;
  logic [31:0] rdata;
  logic        rerr;
  logic [31:0] m_rx;
  logic [31:0] m_irq;
  logic [31:0] m_mask;
  logic [31:0] r;
  logic [31:0] q;
  int          bad_count = 0;
  int          compares = 0;
  int          ld_cnt = 0;
  int          rf_cnt = 0;
  int          base;

  // ------------------------------------------------------------
  // design and clock
  // ------------------------------------------------------------
  mesim_top mesim_top_i (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .clk_en_i(1'b1),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr),
    .rx_fetch_owned_by_cpu_i(ev[0]), .rx_frame_stored_i(ev[1]),
    .rx_overrun_i(ev[2]), .mgmt_done_i(ev[3]),
    .rx_used_hit_i(ev[4]), .tx_used_hit_i(ev[5]),
    .tx_underrun_i(ev[6]), .tx_retry_limit_i(ev[7]),
    .tx_exhausted_i(ev[8]), .tx_complete_i(ev[9]),
    .bus_error_i(ev[10]), .pause_frame_i(ev[11]),
    .pause_zero_i(ev[12]), .tx_frame_start_i(fstart),
    .tx_frame_first_buf_i(fbuf), .tx_active_i(tx_act),
    .txq_ptr_wr_o(ptr_wr), .txq_ptr_load_o(ptr_ld),
    .rx_refetch_o(refetch), .irq_o(irq)
  );

  // 250 MHz system clock
  always #2 sys_clk_i = ~sys_clk_i;

  // count one-cycle pulses so that their timing need not be guessed
  always @(posedge sys_clk_i) begin
    if (ptr_ld === 1'b1) ld_cnt++;
    if (refetch === 1'b1) rf_cnt++;
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] e,
                          input logic [31:0] care);
    compares++;
    if (((got ^ e) & care) !== 32'h0) begin
      bad_count++;
      $display("wrong value at %0t: word %h expected %h", $time, got, e);
    end
  endtask

  // caller passes a value read at a clock edge, before its updates land
  task automatic chk_bit(input logic got, input logic e);
    compares++;
    if (got !== e) begin
      bad_count++;
      $display("wrong value at %0t: bit %b expected %b", $time, got, e);
    end
  endtask

  // one bus transfer; request held until ready is seen high
  task automatic bus(input logic [11:0] a, input logic w,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge sys_clk_i);
    penable <= 1'b1;
    // read at the edge itself: outputs still show the pre-edge values
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      bad_count++;
      report_and_stop();
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e,
                     input logic [31:0] care);
    bus(a, 1'b0, 32'h0);
    chk_word(rdata, e, care);
  endtask

  // one-cycle event; returns once its effect shows at the outputs
  task automatic pulse(input int i);
    @(posedge sys_clk_i);
    ev <= 13'h1 << i;
    @(posedge sys_clk_i);
    ev <= 13'h0;
    @(posedge sys_clk_i);
  endtask

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    #40000;
    bad_count++;
    report_and_stop();
  end

  initial begin
    void'($urandom(32'h288D));
    m_rx = 32'h0;
    m_irq = 32'h0;
    m_mask = 32'h3CFF;
    repeat (3) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rdc(`MESIM_OFS_MASK_ST, m_mask, ALL);
    rdc(`MESIM_OFS_RX_FLAGS, m_rx, ALL);
    rdc(`MESIM_OFS_IRQ_FLAGS, m_irq, ALL);
    chk_bit(irq, 1'b0);
    bus(12'h0FC, 1'b0, 32'h0);
    chk_bit(rerr, 1'b1);
    chk_word(rdata, 32'h0, ALL);
    $display("test reset done");
    // each source once; sources 0 to 2 set receive flags and all but source 0 set interrupt flags, as given in the tables
    for (int i = 0; i < 13; i++) begin
      pulse(i);
      m_rx = m_rx | RX_TAB[i];
      m_irq = m_irq | IRQ_TAB[i];
      rdc(`MESIM_OFS_RX_FLAGS, m_rx, ALL);
      rdc(`MESIM_OFS_IRQ_FLAGS, m_irq, ALL);
      m_irq = 32'h0;
      rdc(`MESIM_OFS_IRQ_FLAGS, m_irq, ALL);
      bus(`MESIM_OFS_RX_FLAGS, 1'b1, 32'h0);
      rdc(`MESIM_OFS_RX_FLAGS, m_rx, ALL);
      bus(`MESIM_OFS_RX_FLAGS, 1'b1, 32'h7);
      m_rx = 32'h0;
      rdc(`MESIM_OFS_RX_FLAGS, m_rx, ALL);
    end
    $display("test events done");
    // failed fetch repeats, then a frame arrives while it is flagged
    pulse(0);
    bus(`MESIM_OFS_RX_FLAGS, 1'b1, 32'h1);
    pulse(0);
    rdc(`MESIM_OFS_RX_FLAGS, 32'h1, ALL);
    base = rf_cnt;
    pulse(1);
    pulse(2);
    rdc(`MESIM_OFS_RX_FLAGS, 32'h7, ALL);
    chk_word(32'(rf_cnt - base), 32'h1, ALL);
    bus(`MESIM_OFS_RX_FLAGS, 1'b1, 32'h2);
    rdc(`MESIM_OFS_RX_FLAGS, 32'h5, ALL);
    bus(`MESIM_OFS_RX_FLAGS, 1'b1, ALL);
    bus(`MESIM_OFS_RX_FLAGS, 1'b1, ALL);
    rdc(`MESIM_OFS_RX_FLAGS, 32'h0, ALL);
    bus(`MESIM_OFS_IRQ_FLAGS, 1'b0, 32'h0);
    $display("test refetch done");
    // random unmask and mask patterns, reserved bits stay zero
    for (int k = 0; k < 4; k++) begin
      r = $urandom;
      bus(`MESIM_OFS_UNMASK, 1'b1, r);
      m_mask = m_mask & ~r;
      rdc(`MESIM_OFS_MASK_ST, m_mask, ALL);
      r = $urandom;
      bus(`MESIM_OFS_MASK, 1'b1, r);
      m_mask = (m_mask | r) & 32'h3CFF;
      rdc(`MESIM_OFS_MASK_ST, m_mask, ALL);
    end
    bus(`MESIM_OFS_MASK_ST, 1'b1, ALL);
    bus(`MESIM_OFS_IRQ_FLAGS, 1'b1, ALL);
    rdc(`MESIM_OFS_MASK_ST, m_mask, ALL);
    rdc(`MESIM_OFS_IRQ_FLAGS, 32'h0, ALL);
    rdc(`MESIM_OFS_UNMASK, 32'h0, ALL);
    rdc(`MESIM_OFS_MASK, 32'h0, ALL);
    // interrupt line follows flag and mask
    bus(`MESIM_OFS_UNMASK, 1'b1, 32'h3CFF);
    pulse(9);
    chk_bit(irq, 1'b1);
    bus(`MESIM_OFS_MASK, 1'b1, 32'h80);
    chk_bit(irq, 1'b0);
    bus(`MESIM_OFS_UNMASK, 1'b1, 32'h80);
    chk_bit(irq, 1'b1);
    bus(`MESIM_OFS_IRQ_FLAGS, 1'b0, 32'h0);
    chk_bit(irq, 1'b0);
    $display("test masks done");
    // queue pointer: written value, frame start, write while busy
    base = ld_cnt;
    r = $urandom;
    bus(`MESIM_OFS_TXQ_PTR, 1'b1, r);
    chk_word(ptr_wr, r, ALL);
    rdc(`MESIM_OFS_TXQ_PTR, r, ALL);
    chk_word(32'(ld_cnt - base), 32'h1, ALL);
    rdc(`MESIM_OFS_IRQ_FLAGS, 32'h10, ALL);
    q = $urandom;
    @(posedge sys_clk_i);
    fstart <= 1'b1;
    fbuf <= q;
    @(posedge sys_clk_i);
    fstart <= 1'b0;
    tx_act <= 1'b1;
    rdc(`MESIM_OFS_TXQ_PTR, q, ALL);
    bus(`MESIM_OFS_TXQ_PTR, 1'b1, ~q);
    rdc(`MESIM_OFS_TXQ_PTR, q, ALL);
    rdc(`MESIM_OFS_IRQ_FLAGS, 32'h0, ALL);
    chk_word(32'(ld_cnt - base), 32'h1, ALL);
    tx_act <= 1'b0;
    $display("test pointer done");
    report_and_stop();
  end
endmodule
